//--- shared/uhd_consts.svh
// constants for the uart holding, interrupt enable and dma ready block
`ifndef UHD_CONSTS_SVH
`define UHD_CONSTS_SVH

// ======================================================================
// register offsets on the three address pins
`define UHD_OFS_HOLD      3'h0
`define UHD_OFS_IRQ_EN    3'h1
`define UHD_OFS_FIFO_CTL  3'h2
`define UHD_OFS_LINE_CTL  3'h3
`define UHD_OFS_LINE_STAT 3'h5

// ======================================================================
// field positions
`define UHD_FCR_EN        0
`define UHD_FCR_DMA       3
`define UHD_FCR_TRIG_LO   6
`define UHD_LCR_DIV_EN    7

// ======================================================================
// reset values
`define UHD_IER_RST       4'h0
`define UHD_LCR_RST       8'h00
`define UHD_LSR_RST       8'h60

// ======================================================================
// receive trigger levels for the two select bits
`define UHD_TRIG_0        5'h01
`define UHD_TRIG_1        5'h04
`define UHD_TRIG_2        5'h08
`define UHD_TRIG_3        5'h0E

// ======================================================================
// fifo depth and 16x tick counts
`define UHD_FIFO_DEPTH    5'h10
`define UHD_TICKS_BIT     4'hF
`define UHD_TICKS_START   4'h7

`endif

//--- shared/uhd_pkg.sv
// types shared by the uart holding block
`default_nettype none
package uhd_pkg;
  // receiver sequence, one-hot
  typedef enum logic [3:0] {
    UHD_RX_IDLE  = 4'h1,
    UHD_RX_START = 4'h2,
    UHD_RX_DATA  = 4'h4,
    UHD_RX_STOP  = 4'h8
  } uhd_rx_state_e;
  // transmitter sequence, one-hot
  typedef enum logic [1:0] {
    UHD_TX_IDLE  = 2'h1,
    UHD_TX_SHIFT = 2'h2
  } uhd_tx_state_e;
endpackage : uhd_pkg
`default_nettype wire

//--- design/uhd_rx_shifter.sv
// receive shifter with false start bit rejection on 16x ticks
`include "uhd_consts.svh"
`default_nettype none
module uhd_rx_shifter
  import uhd_pkg::*;
(
  input  wire logic       clk_sys_in,   // system clock
  input  wire logic       arst_n_in,    // async reset, active low
  input  wire logic       tick_in,      // 16x baud pulse
  input  wire logic       rx_in,        // synchronised serial input
  output logic [7:0]      byte_out,     // assembled character
  output logic            valid_out,    // one-cycle character pulse
  output logic            frame_err_out,// stop bit was low
  output logic            break_out     // all zero with low stop
);
  uhd_rx_state_e state;     // sequence state
  logic [3:0]    tick_cnt;  // ticks within a bit
  logic [2:0]    bit_cnt;   // data bit index
  logic          rx_prev;   // line one cycle back

  // ====================================================================
  // line history for falling edge detection
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) rx_prev <= 1'b1;
    else            rx_prev <= rx_in;
  end

  // ====================================================================
  // start check, data assembly and stop sampling
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state         <= UHD_RX_IDLE;
      tick_cnt      <= 4'h0;
      bit_cnt       <= 3'h0;
      byte_out      <= 8'h00;
      valid_out     <= 1'b0;
      frame_err_out <= 1'b0;
      break_out     <= 1'b0;
    end else begin
      valid_out <= 1'b0;
      unique case (state)
        UHD_RX_IDLE: begin
          // falling edge starts the count
          if (rx_prev && !rx_in) begin // R5
            state    <= UHD_RX_START;
            tick_cnt <= 4'h0;
          end
        end
        UHD_RX_START: if (tick_in) begin
          tick_cnt <= tick_cnt + 4'h1;
          // mid start bit: still low or dropped
          if (tick_cnt == `UHD_TICKS_START) begin
            tick_cnt <= 4'h0;
            bit_cnt  <= 3'h0;
            state    <= rx_in ? UHD_RX_IDLE : UHD_RX_DATA; // R5
          end
        end
        UHD_RX_DATA: if (tick_in) begin
          tick_cnt <= tick_cnt + 4'h1;
          if (tick_cnt == `UHD_TICKS_BIT) begin
            byte_out <= {rx_in, byte_out[7:1]};
            bit_cnt  <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) state <= UHD_RX_STOP;
          end
        end
        UHD_RX_STOP: if (tick_in) begin
          tick_cnt <= tick_cnt + 4'h1;
          if (tick_cnt == `UHD_TICKS_BIT) begin
            valid_out     <= 1'b1;
            frame_err_out <= !rx_in;
            break_out     <= !rx_in && (byte_out == 8'h00);
            state         <= UHD_RX_IDLE;
          end
        end
      endcase
    end
  end

  // ====================================================================
  // checks
  property p_false_start;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (state == UHD_RX_START && tick_in && tick_cnt == `UHD_TICKS_START && rx_in)
      |=> state == UHD_RX_IDLE;
  endproperty
  a_false_start: assert property (p_false_start) // R5
    else $error("false start bit was not rejected");
endmodule // uhd_rx_shifter
`default_nettype wire

//--- design/uhd_holding.sv
// uart holding registers, interrupt enables, fifo status and dma ready pins
// Functional notes
// R1 - write holding register when room exists
// R2 - holding empty flag set on move
// R3 - host writes only while flag high
// R4 - holding read returns and pops oldest
// R5 - falling edge, check start at mid bit
// R6 - enable bit 3 gates modem interrupt
// R7 - enable bit 2 gates line status interrupt
// R8 - enable bit 1 gates transmit empty interrupt
// R9 - enable bit 0 gates trigger level interrupt
// R10 - status register shows trigger level condition
// R11 - data ready while fifo not empty
// R12 - all enables clear gives polled mode
// R13 - status bits one to four report errors; bit 2 (parity) is tied low, no parity is checked
// R14 - status bit 5 transmit fifo empty
// R15 - status bit 6 fifo and shifter empty
// R16 - status bit 7 any fifo data error
// R17 - mode 0 transmit ready low on space
// R18 - mode 0 receive ready low on data
// R19 - block mode transmit interrupt when empty
// R20 - block mode receive interrupt, keeps filling
// R21 - block mode receive ready held above trigger
// R22 - block mode transmit ready full high, empty low
// R23 - control bits 7:6 pick trigger level
// R24 - host keeps divisor enable low
// R25 - sixteen deep fifos, shifter reloads when idle
// R26 - interrupt is or of enabled sources
`include "uhd_consts.svh"
`default_nettype none
module uhd_holding
  import uhd_pkg::*;
(
  input  wire logic       clk_sys_in,       // 20 MHz system clock
  input  wire logic       arst_n_in,        // async reset, active low
  input  wire logic       cs_n_in,          // chip select pin
  input  wire logic       rd_n_in,          // read strobe pin
  input  wire logic       wr_n_in,          // write strobe pin
  input  wire logic [2:0] addr_in,          // register address pins
  input  wire logic [7:0] data_in,          // data bus input side
  output logic      [7:0] data_out,         // data bus output side
  output logic            data_oe_out,      // data bus drive enable
  input  wire logic       baud16_in,        // 16x baud clock pin
  input  wire logic       rx_in,            // serial input pin
  input  wire logic       modem_event_in,   // modem status change level
  output logic            tx_out,           // serial output pin
  output logic            int_out,          // interrupt, active high
  output logic            tx_dma_request_n_out, // transmit ready, low
  output logic            rx_dma_request_n_out  // receive ready, low
);
  // ====================================================================
  // pin synchronisers
  localparam int SW = 17;
  logic [SW-1:0] pin_s1;  // first stage, read only by second
  logic [SW-1:0] pin_s2;  // second stage
  logic          cs_n_s, rd_n_s, wr_n_s, baud_s, rx_s, msi_s;
  logic [2:0]    addr_s;
  logic [7:0]    din_s;

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pin_s1 <= 17'h1D000;
      pin_s2 <= 17'h1D000;
    end else begin
      pin_s1 <= {cs_n_in, rd_n_in, wr_n_in, baud16_in, rx_in, modem_event_in,
                 addr_in, data_in};
      pin_s2 <= pin_s1;
    end
  end
  assign {cs_n_s, rd_n_s, wr_n_s, baud_s, rx_s, msi_s, addr_s, din_s} = pin_s2;

  // ====================================================================
  // strobe edge detection
  logic rd_act, wr_act, rd_act_q, wr_act_q, baud_q;
  logic rd_go, wr_go, tick;
  assign rd_act = !cs_n_s && !rd_n_s;
  assign wr_act = !cs_n_s && !wr_n_s;
  assign rd_go  = rd_act && !rd_act_q;  // one pulse per read
  assign wr_go  = wr_act && !wr_act_q;  // one pulse per write
  assign tick   = baud_s && !baud_q;    // 16x tick

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_act_q <= 1'b0;
      wr_act_q <= 1'b0;
      baud_q   <= 1'b0;
    end else begin
      rd_act_q <= rd_act;
      wr_act_q <= wr_act;
      baud_q   <= baud_s;
    end
  end

  // ====================================================================
  // control registers
  logic [3:0] irq_en;     // interrupt enable bits
  logic       fifo_en;    // fifo enable
  logic       dma_sel;    // dma mode select
  logic [1:0] trig_sel;   // receive trigger select
  logic [7:0] line_ctl;   // line control, divisor enable used
  logic       gen_set;    // general register set visible
  logic       dma_mode;   // block mode active
  logic [4:0] cap;        // usable fifo depth
  assign gen_set  = !line_ctl[`UHD_LCR_DIV_EN]; // R24
  assign dma_mode = fifo_en && dma_sel;
  assign cap      = fifo_en ? `UHD_FIFO_DEPTH : 5'h01; // R25

  // trigger level decode, used by interrupt and dma logic
  function automatic logic [4:0] trig_level(input logic [1:0] sel);
    unique case (sel)
      2'h0: trig_level = `UHD_TRIG_0;
      2'h1: trig_level = `UHD_TRIG_1;
      2'h2: trig_level = `UHD_TRIG_2;
      2'h3: trig_level = `UHD_TRIG_3;
    endcase
  endfunction

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_en   <= `UHD_IER_RST; // R6
      fifo_en  <= 1'b0;
      dma_sel  <= 1'b0;
      trig_sel <= 2'h0;
      line_ctl <= `UHD_LCR_RST;
    end else if (wr_go) begin
      if (addr_s == `UHD_OFS_IRQ_EN && gen_set) irq_en <= din_s[3:0];
      if (addr_s == `UHD_OFS_FIFO_CTL) begin
        fifo_en  <= din_s[`UHD_FCR_EN];
        dma_sel  <= din_s[`UHD_FCR_DMA];
        trig_sel <= din_s[`UHD_FCR_TRIG_LO +: 2]; // R23
      end
      if (addr_s == `UHD_OFS_LINE_CTL) line_ctl <= din_s;
    end
  end

  // ====================================================================
  // transmit fifo
  logic [7:0] tx_mem [16];  // transmit characters
  logic [3:0] tx_wp, tx_rp; // write and read pointers
  logic [4:0] tx_cnt;       // fill level
  logic       tx_push, tx_pop;
  uhd_tx_state_e tx_state;  // shifter state
  assign tx_push = wr_go && gen_set && addr_s == `UHD_OFS_HOLD
                   && tx_cnt < cap;                         // R1
  assign tx_pop  = tx_state == UHD_TX_IDLE && tx_cnt != 5'h00; // R25

  always_ff @(posedge clk_sys_in) begin
    if (tx_push) tx_mem[tx_wp] <= din_s;
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tx_wp  <= 4'h0;
      tx_rp  <= 4'h0;
      tx_cnt <= 5'h00;
    end else begin
      if (tx_push) tx_wp <= tx_wp + 4'h1;
      if (tx_pop)  tx_rp <= tx_rp + 4'h1;
      tx_cnt <= tx_cnt + {4'h0, tx_push} - {4'h0, tx_pop}; // R2
    end
  end

  // ====================================================================
  // transmit shifter, one start, eight data, one stop
  logic [9:0] tx_frame;  // bits still to send, lsb first
  logic [3:0] tx_ticks;  // ticks within a bit
  logic [3:0] tx_bits;   // bits left

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tx_state <= UHD_TX_IDLE;
      tx_frame <= 10'h3FF;
      tx_ticks <= 4'h0;
      tx_bits  <= 4'h0;
      tx_out   <= 1'b1;
    end else begin
      unique case (tx_state)
        UHD_TX_IDLE: begin
          tx_out <= 1'b1;
          // load next character as soon as one waits
          if (tx_pop) begin // R25
            tx_frame <= {1'b1, tx_mem[tx_rp], 1'b0};
            tx_bits  <= 4'hA;
            tx_ticks <= 4'h0;
            tx_state <= UHD_TX_SHIFT;
          end
        end
        UHD_TX_SHIFT: begin
          tx_out <= tx_frame[0];
          if (tick) begin
            tx_ticks <= tx_ticks + 4'h1;
            if (tx_ticks == `UHD_TICKS_BIT) begin
              tx_frame <= {1'b1, tx_frame[9:1]};
              tx_bits  <= tx_bits - 4'h1;
              if (tx_bits == 4'h1) tx_state <= UHD_TX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ====================================================================
  // receiver and receive fifo
  logic [7:0] rx_byte;
  logic       rx_valid, rx_fe, rx_bi;
  logic [9:0] rx_mem [16];  // break, framing, data
  logic [3:0] rx_wp, rx_rp;
  logic [4:0] rx_cnt;       // fill level
  logic [4:0] err_cnt;      // entries holding an error
  logic       rx_push, rx_pop, rx_ovr_evt, hd_err;
  logic [9:0] rx_head;

  uhd_rx_shifter u_rx (
    .clk_sys_in    (clk_sys_in),
    .arst_n_in     (arst_n_in),
    .tick_in       (tick),
    .rx_in         (rx_s),
    .byte_out      (rx_byte),
    .valid_out     (rx_valid),
    .frame_err_out (rx_fe),
    .break_out     (rx_bi)
  );

  assign rx_head    = rx_mem[rx_rp];
  assign hd_err     = rx_head[9] || rx_head[8];
  assign rx_push    = rx_valid && rx_cnt < cap; // R20
  assign rx_ovr_evt = rx_valid && rx_cnt >= cap;
  assign rx_pop     = rd_go && gen_set && addr_s == `UHD_OFS_HOLD
                      && rx_cnt != 5'h00;       // R4

  always_ff @(posedge clk_sys_in) begin
    if (rx_push) rx_mem[rx_wp] <= {rx_bi, rx_fe, rx_byte};
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx_wp   <= 4'h0;
      rx_rp   <= 4'h0;
      rx_cnt  <= 5'h00;
      err_cnt <= 5'h00;
    end else begin
      if (rx_push) rx_wp <= rx_wp + 4'h1;
      if (rx_pop)  rx_rp <= rx_rp + 4'h1;
      rx_cnt  <= rx_cnt + {4'h0, rx_push} - {4'h0, rx_pop}; // R11
      err_cnt <= err_cnt + {4'h0, rx_push && (rx_fe || rx_bi)}
                 - {4'h0, rx_pop && hd_err};                // R16
    end
  end

  // ====================================================================
  // line status
  logic       ovr;      // sticky overrun
  logic [7:0] line_status_reg;      // assembled status
  logic       lsr_rd;
  assign lsr_rd = rd_go && addr_s == `UHD_OFS_LINE_STAT;
  assign line_status_reg = {fifo_en && err_cnt != 5'h00,              // R16
                tx_cnt == 5'h00 && tx_state == UHD_TX_IDLE, // R15
                tx_cnt == 5'h00,                          // R14
                rx_cnt != 5'h00 && rx_head[9],            // R13
                rx_cnt != 5'h00 && rx_head[8],
                1'b0,                                     // no parity
                ovr,
                rx_cnt != 5'h00};                         // R11

  // overrun sticky, new event wins over read clear
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) ovr <= 1'b0;
    else            ovr <= (ovr && !lsr_rd) || rx_ovr_evt; // R13
  end

  // ====================================================================
  // interrupt sources
  logic       rls_pend, rxd_pend, thr_pend, msi_pend, any_pend;
  logic [7:0] irq_status_reg;
  assign rls_pend = irq_en[2] && (line_status_reg[1] || line_status_reg[3] || line_status_reg[4]);   // R7
  assign rxd_pend = irq_en[0] && rx_cnt >= (fifo_en ? trig_level(trig_sel)
                                                    : 5'h01);   // R9
  assign thr_pend = irq_en[1] && (dma_mode ? tx_cnt == 5'h00     // R19
                                           : tx_cnt < cap);      // R8
  assign msi_pend = irq_en[3] && msi_s;                          // R6
  assign any_pend = rls_pend || rxd_pend || thr_pend || msi_pend;
  assign irq_status_reg = {fifo_en, fifo_en, 2'h0,
                rls_pend ? 3'h3 : rxd_pend ? 3'h2 :
                thr_pend ? 3'h1 : 3'h0, !any_pend};              // R10

  // interrupt pin, all enables clear leaves it low
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) int_out <= 1'b0;
    else            int_out <= any_pend; // R26 R12
  end

  // ====================================================================
  // dma ready pins
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tx_dma_request_n_out <= 1'b0;
      rx_dma_request_n_out <= 1'b1;
    end else if (!dma_mode) begin
      tx_dma_request_n_out <= !(tx_cnt < cap);   // R17
      rx_dma_request_n_out <= rx_cnt == 5'h00;   // R18
    end else begin
      // block mode: hold between the two limits
      if (tx_cnt == cap)          tx_dma_request_n_out <= 1'b1; // R22
      else if (tx_cnt == 5'h00)   tx_dma_request_n_out <= 1'b0;
      if (rx_cnt >= trig_level(trig_sel)) rx_dma_request_n_out <= 1'b0; // R21
      else if (rx_cnt == 5'h00)   rx_dma_request_n_out <= 1'b1;
    end
  end

  // ====================================================================
  // read data path
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      data_out    <= 8'h00;
      data_oe_out <= 1'b0;
    end else begin
      data_oe_out <= rd_act;
      if (rd_go) begin
        unique case (addr_s)
          `UHD_OFS_HOLD:      data_out <= gen_set ? rx_head[7:0] : 8'h00; // R4
          `UHD_OFS_IRQ_EN:    data_out <= gen_set ? {4'h0, irq_en} : 8'h00;
          `UHD_OFS_FIFO_CTL:  data_out <= irq_status_reg;
          `UHD_OFS_LINE_CTL:  data_out <= line_ctl;
          `UHD_OFS_LINE_STAT: data_out <= line_status_reg;
          default:            data_out <= 8'h00;
        endcase
      end
    end
  end

  // ====================================================================
  // checks
  property p_tx_full_drop;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (tx_cnt == cap && !tx_pop && fifo_en && $stable(fifo_en)) |=> tx_cnt == cap;
  endproperty
  a_tx_full_drop: assert property (p_tx_full_drop) // R1
    else $error("transmit fifo grew past full");

  property p_tx_load;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (tx_state == UHD_TX_IDLE && tx_cnt != 5'h00) |=> tx_state == UHD_TX_SHIFT;
  endproperty
  a_tx_load: assert property (p_tx_load) // R25
    else $error("shifter did not load waiting character");

  property p_rx_pop;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (rx_pop && !rx_push) |=> rx_cnt == $past(rx_cnt) - 5'h01;
  endproperty
  a_rx_pop: assert property (p_rx_pop) // R4
    else $error("holding read did not remove a character");

  property p_ready_bit;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (rx_push && !dma_mode) |=> line_status_reg[0] ##1 !rx_dma_request_n_out;
  endproperty
  a_ready_bit: assert property (p_ready_bit) // R11
    else $error("data ready missing after receive");

  property p_temt;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    line_status_reg[6] |-> line_status_reg[5] && tx_out;
  endproperty
  a_temt: assert property (p_temt) // R15
    else $error("transmit empty while busy");

  property p_irq_or;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (irq_en == 4'h0) |=> !int_out;
  endproperty
  a_irq_or: assert property (p_irq_or) // R12
    else $error("interrupt with all enables clear");

  property p_rx_trig;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (fifo_en && irq_en[0] && rx_cnt >= trig_level(trig_sel)) |=> int_out;
  endproperty
  a_rx_trig: assert property (p_rx_trig) // R9
    else $error("trigger level reached without interrupt");

  property p_txrdy0;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (!dma_mode && tx_cnt == 5'h00) |=> !tx_dma_request_n_out;
  endproperty
  a_txrdy0: assert property (p_txrdy0) // R17
    else $error("transmit ready high with space");

  property p_txrdy1;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (dma_mode && tx_cnt == cap) |=> tx_dma_request_n_out;
  endproperty
  a_txrdy1: assert property (p_txrdy1) // R22
    else $error("block mode transmit ready low when full");

  c_block_mode: cover property (@(posedge clk_sys_in) dma_mode && rx_cnt == cap);
  c_overrun:    cover property (@(posedge clk_sys_in) rx_ovr_evt);
  c_tx_done:    cover property (@(posedge clk_sys_in) tx_state == UHD_TX_SHIFT ##1
                                tx_state == UHD_TX_IDLE);
endmodule // uhd_holding
`default_nettype wire

//--- verif/uhd_serial_model.sv
// serial far end: 16x baud source, receive line driver, transmit line monitor
`default_nettype none
module uhd_serial_model (
  input  wire logic       clk_sys_in, // bench clock
  input  wire logic       tx_in,      // design serial output
  output logic            baud16_out, // 16x baud clock, 4 clocks
  output logic            rx_out,     // line into the design
  output logic [7:0]      tx_byte_out,// last captured character
  output logic [7:0]      tx_cnt_out  // characters captured
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cap; // shift capture
  initial begin
    baud16_out = 1'b0;
    rx_out = 1'b1;
    tx_byte_out = 8'h00;
    tx_cnt_out = 8'h00;
  end
  // baud source, edges land on falling clock edges
  always begin
    repeat (2) @(negedge clk_sys_in);
    baud16_out = ~baud16_out;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge baud16_out);
  endtask
  // one 8n1 frame, lsb first, stop level chosen
  task automatic send(input logic [7:0] b, input logic stop);
    rx_out = 1'b0;
    tick(16);
    for (int i = 0; i < 8; i++) begin
      rx_out = b[i];
      tick(16);
    end
    rx_out = stop;
    tick(16);
    rx_out = 1'b1;
    tick(16);
  endtask
  // low pulse shorter than half a bit
  task automatic glitch();
    rx_out = 1'b0;
    tick(3);
    rx_out = 1'b1;
    tick(200);
  endtask
  // sample transmit frames at bit centres
  always begin
    @(negedge tx_in);
    tick(8);
    for (int i = 0; i < 8; i++) begin
      tick(16);
      cap[i] = tx_in;
    end
    tick(16);
    tx_byte_out = cap;
    tx_cnt_out = tx_cnt_out + 8'h01;
  end
endmodule // uhd_serial_model
`default_nettype wire

//--- verif/uhd_holding_tb.sv
// self-checking bench for the holding block
`include "uhd_consts.svh"
`default_nettype none
module uhd_holding_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0, rst_n = 1'b0, cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1, mdm = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdat = 8'h00, dout, txb, txc;
  logic       oe, tx, irq, txr_n, rxr_n, b16, rx;
  int         fail_count = 0, cmp_count = 0;
  always #25 clk = ~clk;
  uhd_holding i_dut (.clk_sys_in(clk), .arst_n_in(rst_n), .cs_n_in(cs_n), .rd_n_in(rd_n),
    .wr_n_in(wr_n), .addr_in(addr), .data_in(wdat), .data_out(dout), .data_oe_out(oe),
    .baud16_in(b16), .rx_in(rx), .modem_event_in(mdm), .tx_out(tx), .int_out(irq),
    .tx_dma_request_n_out(txr_n), .rx_dma_request_n_out(rxr_n));
  uhd_serial_model i_far (.clk_sys_in(clk), .tx_in(tx), .baud16_out(b16), .rx_out(rx),
    .tx_byte_out(txb), .tx_cnt_out(txc));
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // strobe held six clocks, address settled three clocks ahead
  task automatic acc(input logic [2:0] a, input logic [7:0] d, input logic w);
    @(negedge clk);
    addr = a;
    wdat = d;
    repeat (3) @(negedge clk);
    cs_n = 1'b0;
    wr_n = ~w;
    rd_n = w;
    repeat (6) @(negedge clk);
    check("bus drive", oe, {7'h00, ~w});
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    repeat (6) @(negedge clk);
  endtask
  task automatic rdc(input string what, input logic [2:0] a, input logic [7:0] exp);
    acc(a, 8'h00, 1'b0);
    check(what, dout, exp);
  endtask
  task automatic pause(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_tx(input logic [7:0] n);
    for (int i = 0; i < 12000 && txc < n; i++) @(negedge clk);
  endtask
  initial begin
    pause(50000);
    fail_count++;
    wrap_up();
  end
  initial begin
    pause(6);
    rst_n = 1'b1;
    pause(1);
    check("int", irq, 8'h00);
    check("tx ready", txr_n, 8'h00);
    check("rx ready", rxr_n, 8'h01);
    rdc("enables", `UHD_OFS_IRQ_EN, 8'h00);
    rdc("status", `UHD_OFS_LINE_STAT, 8'h60);
    acc(`UHD_OFS_FIFO_CTL, 8'h41, 1'b1);
    acc(`UHD_OFS_HOLD, 8'hA5, 1'b1);
    rdc("status busy", `UHD_OFS_LINE_STAT, 8'h20);
    wait_tx(8'h01);
    check("tx byte", txb, 8'hA5);
    pause(60);
    rdc("status idle", `UHD_OFS_LINE_STAT, 8'h60);
    i_far.send(8'h3C, 1'b1);
    pause(4);
    check("rx ready low", rxr_n, 8'h00);
    rdc("status ready", `UHD_OFS_LINE_STAT, 8'h61);
    rdc("rx byte", `UHD_OFS_HOLD, 8'h3C);
    rdc("status drained", `UHD_OFS_LINE_STAT, 8'h60);
    check("rx ready high", rxr_n, 8'h01);
    i_far.glitch();
    rdc("status glitch", `UHD_OFS_LINE_STAT, 8'h60);
    acc(`UHD_OFS_IRQ_EN, 8'h01, 1'b1);
    for (int k = 0; k < 4; k++) begin
      check("int below", irq, 8'h00);
      i_far.send(8'h10 + k[7:0], 1'b1);
    end
    pause(4);
    check("int trigger", irq, 8'h01);
    rdc("status reg", `UHD_OFS_FIFO_CTL, 8'hC4);
    rdc("oldest", `UHD_OFS_HOLD, 8'h10);
    check("int cleared", irq, 8'h00);
    rdc("status reg clr", `UHD_OFS_FIFO_CTL, 8'hC1);
    acc(`UHD_OFS_FIFO_CTL, 8'h49, 1'b1);
    for (int k = 0; k < 3; k++) i_far.send(8'h20 + k[7:0], 1'b1);
    pause(4);
    check("block int", irq, 8'h01);
    check("block rx ready", rxr_n, 8'h00);
    for (int k = 1; k < 4; k++) rdc("fifo order", `UHD_OFS_HOLD, 8'h10 + k[7:0]);
    for (int k = 0; k < 3; k++) rdc("fifo more", `UHD_OFS_HOLD, 8'h20 + k[7:0]);
    check("block rx empty", rxr_n, 8'h01);
    check("block tx empty", txr_n, 8'h00);
    acc(`UHD_OFS_IRQ_EN, 8'h02, 1'b1);
    check("tx int empty", irq, 8'h01);
    acc(`UHD_OFS_HOLD, 8'h5A, 1'b1);
    acc(`UHD_OFS_HOLD, 8'hC3, 1'b1);
    check("tx int held", irq, 8'h00);
    wait_tx(8'h03);
    check("tx second", txb, 8'hC3);
    for (int k = 0; k < 17; k++) acc(`UHD_OFS_HOLD, k[7:0], 1'b1);
    check("block tx full", txr_n, 8'h01);
    wait_tx(8'h14);
    check("block tx last", txb, 8'h10);
    check("block tx drained", txr_n, 8'h00);
    acc(`UHD_OFS_IRQ_EN, 8'h00, 1'b1);
    check("polled", irq, 8'h00);
    mdm = 1'b1;
    pause(4);
    check("modem masked", irq, 8'h00);
    acc(`UHD_OFS_IRQ_EN, 8'h08, 1'b1);
    check("modem on", irq, 8'h01);
    mdm = 1'b0;
    pause(4);
    check("modem off", irq, 8'h00);
    acc(`UHD_OFS_IRQ_EN, 8'h04, 1'b1);
    i_far.send(8'h55, 1'b0);
    pause(4);
    check("line int", irq, 8'h01);
    rdc("errors", `UHD_OFS_LINE_STAT, 8'hE9);
    rdc("bad byte", `UHD_OFS_HOLD, 8'h55);
    check("line int gone", irq, 8'h00);
    wrap_up();
  end
endmodule // uhd_holding_tb
`default_nettype wire
